// file: src/tpg_pkg.sv
// package of constants for the output test-pattern generator
// assumes a single 40 MHz system clock and a plain register port
//
// Summary of operation
// - code 0000 passes samples; 0001 outputs midscale word
// - 0010 all ones, 0011 all zeros, both format converted
// - 0100 alternates 1010.. and 0101.. words, no format
// - 0111 alternates all ones and all zeros, no format
// - 1000 alternates two user words from 0x19-0x1A and 0x1B-0x1C
// - 1001 repeats one word of alternating bits starting with one
// - 1010 outputs the single-rate sync word per resolution
// - 1011 outputs only the msb set, same as the strap pattern in 12-bit mode
// - 1100 outputs the mixed-frequency word per resolution
// - all patterns but the prbs and user ones serve 10 and 12 bit words
// - 0110 runs x^9+x^5+1 prbs, period 511, format converted
// - short prbs packed msb first, first word = first 12 bits
// - both prbs seed all ones; initial words 0x07B and 0xFFF
// - 0101 runs x^23+x^18+1 prbs, period 8388607, format converted
// - long prbs bit stream is inverted before packing
// - long prbs packed msb first, first word = first 12 bits
// - port disabled: format strap high twos complement, low offset binary
// - port select and pattern strap high at power-up: constant 1000 0000 0000 on every lane
// - frame and data clocks keep running under the strap pattern
// - port select high: serial clock and data activity is ignored
// - bits 4 and 5 of the test mode register reset the prbs generators
// - codes 0001 to 1100 replace samples with the pattern before formatting; 1101 to 1111 pass samples
// - pattern select code lives in register 0x0D
`default_nettype none
package tpg_pkg;
  // register map, byte addresses
  localparam logic [7:0] ADDR_TEST_MODE = 8'h0D;
  localparam logic [7:0] ADDR_USER1_LO = 8'h19;
  localparam logic [7:0] ADDR_USER1_HI = 8'h1A;
  localparam logic [7:0] ADDR_USER2_LO = 8'h1B;
  localparam logic [7:0] ADDR_USER2_HI = 8'h1C;
  localparam logic [7:0] ADDR_OUT_MODE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // field positions
  localparam int TM_CODE_LSB = 0;
  localparam int TM_RST_LONG = 4;
  localparam int TM_RST_SHORT = 5;
  localparam int OM_TWOS = 0;
  localparam int OM_RES10 = 1;
  // reset values
  localparam logic [7:0] TEST_MODE_RST = 8'h00;
  localparam logic [7:0] OUT_MODE_RST = 8'h00;
  // pattern select codes
  localparam logic [3:0] PAT_OFF = 4'h0;
  localparam logic [3:0] PAT_MID = 4'h1;
  localparam logic [3:0] PAT_PFS = 4'h2;
  localparam logic [3:0] PAT_NFS = 4'h3;
  localparam logic [3:0] PAT_CHECKER = 4'h4;
  localparam logic [3:0] PAT_LONG = 4'h5;
  localparam logic [3:0] PAT_SHORT = 4'h6;
  localparam logic [3:0] PAT_WORD_TOG = 4'h7;
  localparam logic [3:0] PAT_USER = 4'h8;
  localparam logic [3:0] PAT_BIT_TOG = 4'h9;
  localparam logic [3:0] PAT_SYNC = 4'hA;
  localparam logic [3:0] PAT_ONE_HIGH = 4'hB;
  localparam logic [3:0] PAT_MIXED = 4'hC;
  // 12-bit words, msb aligned; 10-bit forms sit in the low bits
  localparam logic [11:0] W12_MID = 12'h800;
  localparam logic [11:0] W12_CHK_A = 12'hAAA;
  localparam logic [11:0] W12_CHK_B = 12'h555;
  localparam logic [11:0] W12_SYNC = 12'h03F;
  localparam logic [11:0] W12_MIXED = 12'hA33;
  localparam logic [11:0] W10_MID = 12'h200;
  localparam logic [11:0] W10_CHK_A = 12'h2AA;
  localparam logic [11:0] W10_CHK_B = 12'h155;
  localparam logic [11:0] W10_SYNC = 12'h01F;
  localparam logic [11:0] W10_MIXED = 12'h263;
  // prbs geometry
  localparam int SHORT_LEN = 9;
  localparam int SHORT_TAP = 5;
  localparam int LONG_LEN = 23;
  localparam int LONG_TAP = 18;
  localparam logic [12:0] SHORT_INIT = 13'h1FE0;
  localparam logic [12:0] LONG_INIT = 13'h1FFF;
endpackage
`default_nettype wire

// file: src/tpg_prbs.sv
// one prbs generator, advancing a whole word of bits per step
// assumes step and seed pulses come from the system clock domain
`default_nettype none
module tpg_prbs #(
  parameter int LEN = 9,
  parameter int TAP = 5,
  parameter int WIDTH = 12,
  parameter bit INVERT = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic seed,
  input wire logic step,
  // packed word, first serial bit in the msb
  output logic [WIDTH-1:0] word
);
  initial begin
    if (TAP >= LEN || LEN < 2 || WIDTH < 1) begin
      $error("tpg_prbs: bad geometry");
    end
  end

  logic [LEN-1:0] state;
  logic [LEN-1:0] next_state;
  logic [WIDTH-1:0] next_word;

  // serial bit = s[LEN-1] ^ s[TAP-1]; shifting in that bit gives the sequence
  always_comb begin
    next_state = state;
    next_word = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      next_word[i] = next_state[LEN-1] ^ next_state[TAP-1] ^ INVERT;
      next_state = {next_state[LEN-2:0], next_state[LEN-1] ^ next_state[TAP-1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || seed) begin
      state <= '1;
    end else if (step) begin
      state <= next_state;
    end
  end

  // word shows the bits that the coming step consumes, msb first, so the
  // first frame after a seed carries the first bits of the sequence
  assign word = next_word;

  AST_PRBS_SEED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    seed |=> state == {LEN{1'b1}}) else $error("prbs seed not all ones");
endmodule
`default_nettype wire

// file: src/tpg_top.sv
// output test-pattern generator of an eight-lane serial converter
// assumes samples arrive one per frame on clk_sys with a frame strobe,
// the link clock is an asynchronous pin sampled here, and straps settle
// before rst_n releases
//
// Added by the designer: the register addresses and the address-and-strobe port.
`default_nettype none
module tpg_top #(
  parameter int LANES = 8,
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // straps and serial pins
  input wire logic format_select_strap,
  input wire logic test_pattern_strap,
  input wire logic port_select_n,
  input wire logic link_clk,
  // sample stream
  input wire logic frame_strobe,
  input wire logic [LANES*WIDTH-1:0] sample_in,
  // formatted stream
  output logic [LANES*WIDTH-1:0] data_out,
  output logic data_valid,
  output logic frame_clock_out,
  output logic data_clock_out
);
  initial begin
    if (WIDTH != 12 || LANES < 1) begin
      $error("tpg_top: word width must be 12");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {link_clk, port_select_n, test_pattern_strap, format_select_strap};
      sync_b <= sync_a;
    end
  end
  wire logic fmt_pin = sync_b[0];
  wire logic tp_pin = sync_b[1];
  wire logic cs_pin = sync_b[2];
  wire logic lclk_pin = sync_b[3];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // straps latched once, four cycles after release so the synchroniser is full
  logic [1:0] boot_cnt;
  logic strap_done;
  logic strap_port_off;
  logic strap_twos;
  logic strap_pattern;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_cnt <= 2'h0;
      strap_done <= 1'b0;
      strap_port_off <= 1'b0;
      strap_twos <= 1'b0;
      strap_pattern <= 1'b0;
    end else if (!strap_done) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == 2'h3) begin
        strap_done <= 1'b1;
        strap_port_off <= cs_pin;
        strap_twos <= cs_pin & fmt_pin;
        strap_pattern <= cs_pin & tp_pin;
      end
    end
  end

  // port select high shuts the register port off
  wire logic port_on = strap_done & !cs_pin;
  wire logic wr_ok = reg_wr & port_on;
  wire logic rd_ok = reg_rd & port_on;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] test_mode;
  logic [7:0] out_mode;
  logic [15:0] user1;
  logic [15:0] user2;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      test_mode <= tpg_pkg::TEST_MODE_RST;
    end else if (wr_ok && reg_addr == tpg_pkg::ADDR_TEST_MODE) begin
      test_mode <= reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out_mode <= tpg_pkg::OUT_MODE_RST;
    end else if (!strap_done) begin
      out_mode <= tpg_pkg::OUT_MODE_RST;
    end else if (strap_port_off) begin
      out_mode[tpg_pkg::OM_TWOS] <= strap_twos;
    end else if (wr_ok && reg_addr == tpg_pkg::ADDR_OUT_MODE) begin
      out_mode <= reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      user1 <= 16'h0000;
      user2 <= 16'h0000;
    end else if (wr_ok) begin
      if (reg_addr == tpg_pkg::ADDR_USER1_LO) user1[7:0] <= reg_wdata;
      if (reg_addr == tpg_pkg::ADDR_USER1_HI) user1[15:8] <= reg_wdata;
      if (reg_addr == tpg_pkg::ADDR_USER2_LO) user2[7:0] <= reg_wdata;
      if (reg_addr == tpg_pkg::ADDR_USER2_HI) user2[15:8] <= reg_wdata;
    end
  end

  wire logic [3:0] code = test_mode[tpg_pkg::TM_CODE_LSB +: 4];
  wire logic twos = out_mode[tpg_pkg::OM_TWOS];
  wire logic res10 = out_mode[tpg_pkg::OM_RES10];
  wire logic strap_active = strap_pattern & strap_port_off;

  logic word_sel;

  // readback; unmapped addresses read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      tpg_pkg::ADDR_TEST_MODE: next_rdata = test_mode;
      tpg_pkg::ADDR_OUT_MODE: next_rdata = out_mode;
      tpg_pkg::ADDR_USER1_LO: next_rdata = user1[7:0];
      tpg_pkg::ADDR_USER1_HI: next_rdata = user1[15:8];
      tpg_pkg::ADDR_USER2_LO: next_rdata = user2[7:0];
      tpg_pkg::ADDR_USER2_HI: next_rdata = user2[15:8];
      tpg_pkg::ADDR_STATUS: next_rdata = {4'h0, lclk_pin, strap_active, word_sel, strap_done};
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (rd_ok) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // pattern sources
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_sel <= 1'b0;
    end else if (frame_strobe) begin
      word_sel <= !word_sel;
    end
  end

  // seed pulses: register bits 4/5 hold the generators at their seed
  wire logic seed_long = test_mode[tpg_pkg::TM_RST_LONG];
  wire logic seed_short = test_mode[tpg_pkg::TM_RST_SHORT];
  logic [WIDTH-1:0] short_word;
  logic [WIDTH-1:0] long_word;

  tpg_prbs #(
    .LEN(tpg_pkg::SHORT_LEN), .TAP(tpg_pkg::SHORT_TAP), .WIDTH(WIDTH), .INVERT(1'b0)
  ) u_short (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .seed(seed_short),
    .step(frame_strobe && code == tpg_pkg::PAT_SHORT),
    .word(short_word)
  );
  tpg_prbs #(
    .LEN(tpg_pkg::LONG_LEN), .TAP(tpg_pkg::LONG_TAP), .WIDTH(WIDTH), .INVERT(1'b1)
  ) u_long (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .seed(seed_long),
    .step(frame_strobe && code == tpg_pkg::PAT_LONG),
    .word(long_word)
  );

  // ----------------------------------------------------------------
  // pattern select and output formatting
  // ----------------------------------------------------------------
  // format applies to offset-binary words by flipping the msb; samples
  // arrive in offset binary, so normal data passes the same stage
  logic [WIDTH-1:0] pat;
  logic fmt_applies;
  logic use_sample;
  always_comb begin
    pat = '0;
    fmt_applies = 1'b0;
    use_sample = 1'b0;
    if (strap_active) begin
      pat = tpg_pkg::W12_MID;
    end else begin
      unique case (code)
        tpg_pkg::PAT_OFF: begin
          use_sample = 1'b1;
          fmt_applies = 1'b1;
        end
        tpg_pkg::PAT_MID: begin
          pat = res10 ? tpg_pkg::W10_MID : tpg_pkg::W12_MID;
          fmt_applies = 1'b1;
        end
        tpg_pkg::PAT_PFS: begin
          pat = res10 ? 12'h3FF : 12'hFFF;
          fmt_applies = 1'b1;
        end
        tpg_pkg::PAT_NFS: begin
          pat = 12'h000;
          fmt_applies = 1'b1;
        end
        tpg_pkg::PAT_CHECKER: begin
          if (res10) pat = word_sel ? tpg_pkg::W10_CHK_B : tpg_pkg::W10_CHK_A;
          else pat = word_sel ? tpg_pkg::W12_CHK_B : tpg_pkg::W12_CHK_A;
        end
        tpg_pkg::PAT_LONG: begin
          pat = long_word;
          fmt_applies = 1'b1;
        end
        tpg_pkg::PAT_SHORT: begin
          pat = short_word;
          fmt_applies = 1'b1;
        end
        tpg_pkg::PAT_WORD_TOG: begin
          pat = word_sel ? 12'h000 : (res10 ? 12'h3FF : 12'hFFF);
        end
        tpg_pkg::PAT_USER: begin
          pat = word_sel ? user2[15:4] : user1[15:4];
        end
        tpg_pkg::PAT_BIT_TOG: begin
          pat = res10 ? tpg_pkg::W10_CHK_A : tpg_pkg::W12_CHK_A;
        end
        tpg_pkg::PAT_SYNC: begin
          pat = res10 ? tpg_pkg::W10_SYNC : tpg_pkg::W12_SYNC;
        end
        tpg_pkg::PAT_ONE_HIGH: begin
          pat = res10 ? tpg_pkg::W10_MID : tpg_pkg::W12_MID;
        end
        tpg_pkg::PAT_MIXED: begin
          pat = res10 ? tpg_pkg::W10_MIXED : tpg_pkg::W12_MIXED;
        end
        default: begin
          use_sample = 1'b1;
          fmt_applies = 1'b1;
        end
      endcase
    end
  end

  // msb position depends on resolution
  wire logic [WIDTH-1:0] fmt_mask = (fmt_applies && twos) ?
    (res10 ? 12'h200 : 12'h800) : 12'h000;

  // the whole lane set is replaced while a pattern runs
  logic [LANES*WIDTH-1:0] next_data;
  always_comb begin
    next_data = '0;
    for (int l = 0; l < LANES; l++) begin
      next_data[l*WIDTH +: WIDTH] = (use_sample ? sample_in[l*WIDTH +: WIDTH] : pat) ^ fmt_mask;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out <= '0;
      data_valid <= 1'b0;
    end else begin
      data_valid <= frame_strobe;
      if (frame_strobe) data_out <= next_data;
    end
  end

  // framing clocks run regardless of pattern mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_clock_out <= 1'b0;
      data_clock_out <= 1'b0;
    end else begin
      frame_clock_out <= frame_strobe;
      data_clock_out <= lclk_pin;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OFF_PASSES: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_strobe && code == tpg_pkg::PAT_OFF && !strap_active) |=>
    data_out == ($past(sample_in) ^ {LANES{$past(twos) ?
    ($past(res10) ? 12'h200 : 12'h800) : 12'h000}}))
    else $error("normal data not passed");
  AST_STRAP_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_strobe && strap_active) |=> data_out[WIDTH-1:0] == tpg_pkg::W12_MID)
    else $error("strap word wrong");
  AST_CHECKER_ALT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_strobe && code == tpg_pkg::PAT_CHECKER && !strap_active && !res10) |=>
    (data_out[WIDTH-1:0] == tpg_pkg::W12_CHK_A || data_out[WIDTH-1:0] == tpg_pkg::W12_CHK_B))
    else $error("checkerboard word wrong");
  AST_SYNC_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_strobe && code == tpg_pkg::PAT_SYNC && !strap_active && !res10) |=>
    data_out[WIDTH-1:0] == tpg_pkg::W12_SYNC) else $error("sync word wrong");
  AST_MIXED_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_strobe && code == tpg_pkg::PAT_MIXED && !strap_active && !res10) |=>
    data_out[WIDTH-1:0] == tpg_pkg::W12_MIXED) else $error("mixed word wrong");
  AST_PFS_TWOS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_strobe && code == tpg_pkg::PAT_PFS && !strap_active && twos && !res10) |=>
    data_out[WIDTH-1:0] == 12'h7FF) else $error("full scale format wrong");
  AST_PORT_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && !port_on) |=> $stable(test_mode)) else $error("write taken while off");
  AST_FRAME_CLK_RUNS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_strobe |=> frame_clock_out) else $error("frame clock stopped");
  COV_STRAP: cover property (@(posedge clk_sys) disable iff (!rst_n) strap_active && frame_strobe);
  COV_SHORT: cover property (@(posedge clk_sys) disable iff (!rst_n)
    frame_strobe && code == tpg_pkg::PAT_SHORT);
  COV_USER: cover property (@(posedge clk_sys) disable iff (!rst_n)
    frame_strobe && code == tpg_pkg::PAT_USER && word_sel);
endmodule
`default_nettype wire

// file: verif/tpg_rx_model.sv
// receiver model for the test-pattern generator: captures the lane words
// assumes data_valid and frame_clock_out are one-cycle pulses on clk_sys
`default_nettype none
module tpg_rx_model #(
  parameter int LANES = 8,
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // lanes from the generator
  input wire logic [LANES*WIDTH-1:0] data_out,
  input wire logic data_valid,
  input wire logic frame_clock_out,
  input wire logic data_clock_out,
  // capture results
  output logic [LANES*WIDTH-1:0] rx_words,
  output int rx_frames,
  output int rx_dclk_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dclk_q;
  // -----------------------------------------------------------------
  // capture
  // -----------------------------------------------------------------
  // a word only counts when the frame clock marks it, as a real receiver aligns
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_words <= '0;
      rx_frames <= 0;
      rx_dclk_edges <= 0;
      dclk_q <= 1'b0;
    end else begin
      if (data_valid && frame_clock_out) begin
        rx_words <= data_out;
        rx_frames <= rx_frames + 1;
      end
      dclk_q <= data_clock_out;
      if (dclk_q != data_clock_out) begin
        rx_dclk_edges <= rx_dclk_edges + 1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/test_adc_output_test_pattern_gen.sv
// self-checking bench for the output test-pattern generator
// assumes tpg_top and tpg_rx_model on a plain one-cycle register port
`default_nettype none
module test_adc_output_test_pattern_gen;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 8;
  localparam int WIDTH = 12;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic format_select_strap = 1'b0;
  logic test_pattern_strap = 1'b0;
  logic port_select_n = 1'b0;
  logic link_clk = 1'b0;
  logic frame_strobe = 1'b0;
  logic [LANES*WIDTH-1:0] sample_in = {LANES{12'h35A}};
  logic [LANES*WIDTH-1:0] data_out;
  logic data_valid;
  logic frame_clock_out;
  logic data_clock_out;
  logic [LANES*WIDTH-1:0] rx_words;
  int rx_frames;
  int rx_dclk_edges;
  int fails = 0;
  int check_count = 0;
  logic [11:0] s_first;
  logic [11:0] l_first;

  always #12.5 clk_sys = ~clk_sys;
  // link clock toggles on clk_sys falling edges, eight clk_sys periods per cycle
  always #100 link_clk = ~link_clk;

  tpg_top #(.LANES(LANES), .WIDTH(WIDTH)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .format_select_strap(format_select_strap), .test_pattern_strap(test_pattern_strap),
    .port_select_n(port_select_n), .link_clk(link_clk), .frame_strobe(frame_strobe),
    .sample_in(sample_in), .data_out(data_out), .data_valid(data_valid),
    .frame_clock_out(frame_clock_out), .data_clock_out(data_clock_out)
  );

  tpg_rx_model #(.LANES(LANES), .WIDTH(WIDTH)) rx (
    .clk_sys(clk_sys), .rst_n(rst_n), .data_out(data_out), .data_valid(data_valid),
    .frame_clock_out(frame_clock_out), .data_clock_out(data_clock_out),
    .rx_words(rx_words), .rx_frames(rx_frames), .rx_dclk_edges(rx_dclk_edges)
  );

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // straps must be steady before release, they are latched just after it
  task automatic do_reset(input logic fs, input logic tp, input logic ps_n);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    format_select_strap <= fs;
    test_pattern_strap <= tp;
    port_select_n <= ps_n;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic frame(output logic [11:0] w0, output logic [11:0] w7);
    int n;
    n = rx_frames;
    @(posedge clk_sys);
    frame_strobe <= 1'b1;
    @(posedge clk_sys);
    frame_strobe <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("frames", 12'(rx_frames - n), 12'h001);
    w0 = rx_words[11:0];
    w7 = rx_words[LANES*WIDTH-1 -: WIDTH];
  endtask

  // expected lane word; 10-bit words sit in the low bits
  function automatic logic [11:0] exp_word(input logic [3:0] c, input logic r10,
      input logic tw, input logic sel);
    logic [11:0] m;
    logic [11:0] f;
    logic [11:0] w;
    m = r10 ? 12'h200 : 12'h800;
    f = r10 ? 12'h3FF : 12'hFFF;
    case (c)
      4'h0: w = 12'h35A;
      4'h1: w = m;
      4'h2: w = f;
      4'h3: w = 12'h000;
      4'h4: w = sel ? (f & 12'h555) : (f & 12'hAAA);
      4'h7: w = sel ? 12'h000 : f;
      4'h8: w = sel ? 12'h2A9 : 12'hC35;
      4'h9: w = f & 12'hAAA;
      4'hA: w = r10 ? 12'h01F : 12'h03F;
      4'hB: w = m;
      default: w = r10 ? 12'h263 : 12'hA33;
    endcase
    if (tw && c <= 4'h3) begin
      w = w ^ m;
    end
    return w;
  endfunction

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic check_regs();
    logic [7:0] d;
    rd(tpg_pkg::ADDR_TEST_MODE, d);
    check("test_mode_rst", {4'h0, d}, 12'h000);
    rd(tpg_pkg::ADDR_OUT_MODE, d);
    check("out_mode_rst", {4'h0, d}, 12'h000);
    rd(8'h33, d);
    check("unmapped", {4'h0, d}, 12'h000);
    wr(tpg_pkg::ADDR_TEST_MODE, 8'h0C);
    rd(tpg_pkg::ADDR_TEST_MODE, d);
    check("test_mode_wr", {4'h0, d}, 12'h00C);
  endtask

  // every fixed code, both formats, both resolutions except codes 0 and 8 (12-bit only), two frames each
  task automatic scan_codes();
    logic [7:0] st;
    logic [11:0] w0;
    logic [11:0] w7;
    logic [11:0] e;
    wr(8'h19, 8'h50);
    wr(8'h1A, 8'hC3);
    wr(8'h1B, 8'h90);
    wr(8'h1C, 8'h2A);
    for (int r = 0; r < 2; r++) begin
      for (int t = 0; t < 2; t++) begin
        wr(tpg_pkg::ADDR_OUT_MODE, {6'h00, r[0], t[0]});
        for (int c = 0; c < 13; c++) begin
          if (c == 5 || c == 6 || (r == 1 && (c == 0 || c == 8))) continue;
          wr(tpg_pkg::ADDR_TEST_MODE, 8'(c));
          rd(tpg_pkg::ADDR_STATUS, st);
          for (int k = 0; k < 2; k++) begin
            frame(w0, w7);
            e = exp_word(4'(c), r[0], t[0], st[1] ^ k[0]);
            check("lane0", w0, e);
            check("lane7", w7, e);
          end
        end
      end
    end
  endtask

  task automatic prbs_pair(input logic [7:0] m, input logic tw, output logic [11:0] a,
      output logic [11:0] b);
    logic [11:0] x;
    wr(tpg_pkg::ADDR_OUT_MODE, {7'h00, tw});
    wr(tpg_pkg::ADDR_TEST_MODE, m);
    wr(tpg_pkg::ADDR_TEST_MODE, m & 8'h0F);
    frame(a, x);
    frame(b, x);
  endtask

  // reseed must replay the sequence; format flips only the msb
  task automatic prbs_test(input logic [7:0] m, input int period, output logic [11:0] a1);
    logic [11:0] a0;
    logic [11:0] b0;
    logic [11:0] b1;
    logic [11:0] x;
    prbs_pair(m, 1'b0, a0, b0);
    prbs_pair(m, 1'b1, a1, b1);
    check("prbs_first", a1, a0 ^ 12'h800);
    check("prbs_second", b1, b0 ^ 12'h800);
    check("prbs_moves", {11'h000, a0 == b0}, 12'h000);
    if (period > 0) begin
      repeat (period - 2) frame(x, x);
      frame(x, b0);
      check("prbs_period", x, a1);
    end
  endtask

  task automatic strap_test();
    logic [11:0] w0;
    logic [11:0] w7;
    logic [7:0] d;
    int e;
    do_reset(1'b1, 1'b1, 1'b1);
    e = rx_dclk_edges;
    frame(w0, w7);
    check("strap_lane0", w0, 12'h800);
    check("strap_lane7", w7, 12'h800);
    wr(tpg_pkg::ADDR_TEST_MODE, 8'h02);
    frame(w0, w7);
    check("strap_hold", w0, 12'h800);
    rd(tpg_pkg::ADDR_TEST_MODE, d);
    check("port_off_read", {4'h0, d}, 12'h000);
    check("dclk_runs", {11'h000, rx_dclk_edges > e}, 12'h001);
    do_reset(1'b1, 1'b0, 1'b1);
    frame(w0, w7);
    check("fmt_strap_high", w0, 12'hB5A);
    do_reset(1'b0, 1'b0, 1'b1);
    frame(w0, w7);
    check("fmt_strap_low", w0, 12'h35A);
  endtask

  // -----------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------
  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    check_regs();
    scan_codes();
    prbs_test(8'h26, 511, s_first);
    prbs_test(8'h15, 0, l_first);
    check("long_vs_short", {11'h000, s_first == l_first}, 12'h000);
    check("long_first", l_first, 12'h7FF);
    strap_test();
    report_and_stop();
  end

  // a hang counts as a mismatch
  initial begin
    #2000000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
